// File: side_bus_timing_defs.svh
// Register offsets, field positions, reset values and masks for the side-bus timing block.
`ifndef SIDE_BUS_TIMING_DEFS_SVH
`define SIDE_BUS_TIMING_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_TIMING_LO      8'h00
`define OFS_TIMING_HI      8'h04
`define OFS_CTRL           8'h08
`define OFS_STATUS         8'h0c
`define OFS_IRQ_DATA_LO    8'h10
`define OFS_IRQ_DATA_HI    8'h14

// ****************************************************************
// Timing register fields
// ****************************************************************
`define TIM_START_LSB      12
`define TIM_READ_LSB       8
`define TIM_SETUP_LSB      4
`define TIM_AHOLD_BIT      1
`define TIM_ASETUP_BIT     0
`define TIM_RW_MASK        32'h0000_7333
`define TIM_RESET          32'h0000_7330

// ****************************************************************
// Control and status fields
// ****************************************************************
`define CTRL_RD_BIT        0
`define CTRL_WR_BIT        1
`define CTRL_SEL_LSB       8
`define CTRL_DATA_LSB      16
`define CTRL_RW_MASK       32'h00ff_0700
`define STAT_BUSY_BIT      0
`define LAST_BYTE          3'h7

`endif

// File: side_bus_timing_pkg.sv
// Types shared by the side-bus timing block.
package side_bus_timing_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ASETUP,
		ST_ASTROBE,
		ST_AHOLD,
		ST_RDRIVE,
		ST_WSETUP,
		ST_WSTROBE
	} seq_state_t;

	typedef logic [1:0] cnt_t;

endpackage

// File: side_bus_interrupt_timing.sv
// AHB-Lite timing register and interrupt transfer sequencer for the auxiliary side bus.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "side_bus_timing_defs.svh"

// Operation
// R1: Same timing for every side-bus transfer.
// R2: Interrupt reads start at programmed byte number.
// R3: Module fills buffers start byte through seven.
// R4: Buffer driver enabled read-time plus one cycles.
// R5: Data driven setup-time plus one before strobe.
// R6: Module latches data on interrupt strobe.
// R7: Address held after strobe before chip select.
// R8: Address setup before address latch strobe.
// R9: Each timed state lasts value plus one.
// R10: Reserved timing bits read as zero.
module side_bus_interrupt_timing #(
	parameter int ADDR_W = 8
) (
	input  wire logic                            i_clk,
	input  wire logic                            i_rst_b,
	input  wire logic                            i_hsel,
	input  wire logic [31:0]                     i_haddr,
	input  wire logic [1:0]                      i_htrans,
	input  wire logic                            i_hwrite,
	input  wire logic [2:0]                      i_hsize,
	input  wire logic                            i_hready,
	input  wire logic [31:0]                     i_hwdata,
	output logic      [31:0]                     o_hrdata,
	output logic                                 o_hreadyout,
	output logic                                 o_hresp,
	output logic      [ADDR_W-1:0]               o_bus_addr,
	output logic                                 o_addr_latch_strobe_n,
	output logic                                 o_chip_sel_n,
	output logic                                 o_irq_buf_oe_n,
	output logic                                 o_irq_strobe,
	output logic      [7:0]                      o_bus_data,
	output logic                                 o_bus_data_oe,
	input  wire logic [7:0]                      i_bus_data
);
	import side_bus_timing_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	logic        [31:0]       timing_q,   timing_d;
	logic        [31:0]       ctrl_q,     ctrl_d;
	logic        [63:0]       irq_q,      irq_d;
	logic        [31:0]       rdata_q,    rdata_d;
	logic                     wr_ph_q,    wr_ph_d;
	logic        [7:0]        wr_addr_q,  wr_addr_d;
	seq_state_t               state_q,    state_d;
	cnt_t                     cnt_q,      cnt_d;
	logic        [2:0]        byte_q,     byte_d;
	logic                     op_rd_q,    op_rd_d;
	logic                     as_n_q,     as_n_d;
	logic                     cs_n_q,     cs_n_d;
	logic                     oe_n_q,     oe_n_d;
	logic                     strobe_q,   strobe_d;
	logic                     doe_q,      doe_d;
	logic        [7:0]        dout_q,     dout_d;
	logic        [ADDR_W-1:0] addr_q,     addr_d;
	logic                     addr_ph;
	logic                     start_rd;
	logic                     start_wr;

	// ****************************************************************
	// Register read decode
	// ****************************************************************
	function automatic logic [31:0] read_word(input logic [7:0] ofs, input logic [31:0] tim,
		input logic [31:0] ctl, input logic [63:0] irq, input logic busy);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (ofs)
			`OFS_TIMING_LO:   w = tim & `TIM_RW_MASK; // [R10]
			`OFS_TIMING_HI:   w = 32'h0000_0000; // [R10]
			`OFS_CTRL:        w = ctl;
			`OFS_STATUS:      w[`STAT_BUSY_BIT] = busy;
			`OFS_IRQ_DATA_LO: w = irq[31:0];
			`OFS_IRQ_DATA_HI: w = irq[63:32];
			default:          w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		timing_d  = timing_q;
		ctrl_d    = ctrl_q;
		irq_d     = irq_q;
		state_d   = state_q;
		cnt_d     = cnt_q;
		byte_d    = byte_q;
		op_rd_d   = op_rd_q;
		addr_d    = addr_q;
		start_rd  = 1'b0;
		start_wr  = 1'b0;
		addr_ph   = i_hsel & i_htrans[1] & i_hready;
		wr_ph_d   = addr_ph & i_hwrite;
		wr_addr_d = addr_ph ? i_haddr[7:0] : wr_addr_q;

		// Bus write data phase.
		if (wr_ph_q) begin
			unique case (wr_addr_q)
				`OFS_TIMING_LO: timing_d = i_hwdata & `TIM_RW_MASK; // [R10]
				`OFS_CTRL: begin
					if (state_q == ST_IDLE) begin
						ctrl_d   = i_hwdata & `CTRL_RW_MASK;
						start_rd = i_hwdata[`CTRL_RD_BIT];
						start_wr = i_hwdata[`CTRL_WR_BIT] & ~i_hwdata[`CTRL_RD_BIT];
					end
				end
				default: ;
			endcase
		end

		// Transfer sequencer; every timed state lasts its field value plus one cycle.
		unique case (state_q)
			ST_IDLE: begin
				if (start_rd) begin
					op_rd_d = 1'b1;
					byte_d  = timing_q[`TIM_START_LSB +: 3]; // [R2]
					irq_d   = 64'h0;
					state_d = ST_ASETUP;
					cnt_d   = {1'b0, timing_q[`TIM_ASETUP_BIT]}; // [R8] [R1]
				end else if (start_wr) begin
					op_rd_d = 1'b0;
					byte_d  = i_hwdata[`CTRL_SEL_LSB +: 3];
					state_d = ST_ASETUP;
					cnt_d   = {1'b0, timing_q[`TIM_ASETUP_BIT]}; // [R8] [R1]
				end
			end
			ST_ASETUP: begin
				if (cnt_q == 2'h0) begin
					state_d = ST_ASTROBE; // [R8] [R9]
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			ST_ASTROBE: begin
				state_d = ST_AHOLD;
				cnt_d   = {1'b0, timing_q[`TIM_AHOLD_BIT]}; // [R7]
			end
			ST_AHOLD: begin
				if (cnt_q != 2'h0) begin
					cnt_d = cnt_q - 2'h1;
				end else if (op_rd_q) begin
					state_d = ST_RDRIVE; // [R7] [R9]
					cnt_d   = timing_q[`TIM_READ_LSB +: 2]; // [R4]
				end else begin
					state_d = ST_WSETUP; // [R7] [R9]
					cnt_d   = timing_q[`TIM_SETUP_LSB +: 2]; // [R5]
				end
			end
			ST_RDRIVE: begin
				if (cnt_q != 2'h0) begin
					cnt_d = cnt_q - 2'h1;
				end else begin
					irq_d[{byte_q, 3'h0} +: 8] = i_bus_data; // [R4] [R3]
					if (byte_q == `LAST_BYTE) begin
						state_d = ST_IDLE;
					end else begin
						byte_d  = byte_q + 3'h1; // [R3]
						state_d = ST_ASETUP;
						cnt_d   = {1'b0, timing_q[`TIM_ASETUP_BIT]}; // [R8]
					end
				end
			end
			ST_WSETUP: begin
				if (cnt_q == 2'h0) begin
					state_d = ST_WSTROBE; // [R5] [R9]
				end else begin
					cnt_d = cnt_q - 2'h1;
				end
			end
			ST_WSTROBE: begin
				state_d = ST_IDLE; // [R6]
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase

		// Pin values follow the next state so they line up with it.
		addr_d   = ADDR_W'(byte_d);
		as_n_d   = (state_d != ST_ASTROBE);
		cs_n_d   = !(state_d inside {ST_RDRIVE, ST_WSETUP, ST_WSTROBE});
		oe_n_d   = (state_d != ST_RDRIVE); // [R4]
		doe_d    = (state_d inside {ST_WSETUP, ST_WSTROBE}); // [R5]
		strobe_d = (state_d == ST_WSTROBE); // [R5] [R6]
		dout_d   = doe_d ? ctrl_d[`CTRL_DATA_LSB +: 8] : 8'h00;

		// Read data are taken from the updated values so a read after a write sees it.
		rdata_d = rdata_q;
		if (addr_ph & ~i_hwrite) begin
			rdata_d = read_word(i_haddr[7:0], timing_d, ctrl_d, irq_d, state_d != ST_IDLE);
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timing_q  <= `TIM_RESET;
			ctrl_q    <= 32'h0000_0000;
			irq_q     <= 64'h0;
			rdata_q   <= 32'h0000_0000;
			wr_ph_q   <= 1'b0;
			wr_addr_q <= 8'h00;
			state_q   <= ST_IDLE;
			cnt_q     <= 2'h0;
			byte_q    <= 3'h0;
			op_rd_q   <= 1'b0;
			as_n_q    <= 1'b1;
			cs_n_q    <= 1'b1;
			oe_n_q    <= 1'b1;
			strobe_q  <= 1'b0;
			doe_q     <= 1'b0;
			dout_q    <= 8'h00;
			addr_q    <= '0;
		end else begin
			timing_q  <= timing_d;
			ctrl_q    <= ctrl_d;
			irq_q     <= irq_d;
			rdata_q   <= rdata_d;
			wr_ph_q   <= wr_ph_d;
			wr_addr_q <= wr_addr_d;
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			byte_q    <= byte_d;
			op_rd_q   <= op_rd_d;
			as_n_q    <= as_n_d;
			cs_n_q    <= cs_n_d;
			oe_n_q    <= oe_n_d;
			strobe_q  <= strobe_d;
			doe_q     <= doe_d;
			dout_q    <= dout_d;
			addr_q    <= addr_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_hrdata              = rdata_q;
	assign o_hreadyout           = 1'b1;
	assign o_hresp               = 1'b0;
	assign o_bus_addr            = addr_q;
	assign o_addr_latch_strobe_n = as_n_q;
	assign o_chip_sel_n          = cs_n_q;
	assign o_irq_buf_oe_n        = oe_n_q;
	assign o_irq_strobe          = strobe_q;
	assign o_bus_data            = dout_q;
	assign o_bus_data_oe         = doe_q;

endmodule // side_bus_interrupt_timing

// File: side_bus_timing_props.sv
// Checker of the side-bus strobe and hand-over timing at the block ports.
`timescale 1ns/1ps
module side_bus_timing_props #(
	parameter int ADDR_W = 8
) (
	input wire logic              i_clk,
	input wire logic              i_rst_b,
	input wire logic              o_addr_latch_strobe_n,
	input wire logic              o_chip_sel_n,
	input wire logic              o_irq_buf_oe_n,
	input wire logic              o_irq_strobe,
	input wire logic [7:0]        o_bus_data,
	input wire logic              o_bus_data_oe,
	input wire logic [ADDR_W-1:0] o_bus_addr
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	property p_as_setup; $fell(o_addr_latch_strobe_n) |-> $stable(o_bus_addr) && o_chip_sel_n; endproperty
	a_as_setup: assert property (p_as_setup) else $error("address not set up");
	property p_as_pulse; $fell(o_addr_latch_strobe_n) |=> $rose(o_addr_latch_strobe_n); endproperty
	a_as_pulse: assert property (p_as_pulse) else $error("latch strobe width");
	property p_ah; $rose(o_addr_latch_strobe_n) |-> o_chip_sel_n ##[1:2] !o_chip_sel_n; endproperty
	a_ah: assert property (p_ah) else $error("address hold");
	property p_rd_cs; !o_irq_buf_oe_n |-> !o_chip_sel_n && !o_bus_data_oe; endproperty
	a_rd_cs: assert property (p_rd_cs) else $error("buffer enable without select");
	property p_rd_len; $fell(o_irq_buf_oe_n) |-> ##[1:4] $rose(o_irq_buf_oe_n); endproperty
	a_rd_len: assert property (p_rd_len) else $error("read drive length");
	property p_is_len; $rose(o_bus_data_oe) |-> !o_irq_strobe ##[1:4] o_irq_strobe; endproperty
	a_is_len: assert property (p_is_len) else $error("interrupt setup length");
	property p_is_data; o_irq_strobe |-> $past(o_bus_data_oe) && o_bus_data_oe && $stable(o_bus_data); endproperty
	a_is_data: assert property (p_is_data) else $error("data not held at strobe");
	property p_is_pulse; o_irq_strobe |=> !o_irq_strobe && !o_bus_data_oe; endproperty
	a_is_pulse: assert property (p_is_pulse) else $error("interrupt strobe width");
	c_rd: cover property (!o_irq_buf_oe_n ##1 o_irq_buf_oe_n);
	c_wr: cover property (o_irq_strobe);
	c_ah2: cover property ($rose(o_addr_latch_strobe_n) ##2 $fell(o_chip_sel_n));
endmodule // side_bus_timing_props

// File: irq_module_model.sv
// Module-side interrupt buffers and interrupt register on the side bus.
`timescale 1ns/1ps
module irq_module_model (
	input  wire logic       i_clk,
	input  wire logic [2:0] i_first,
	input  wire logic [1:0] i_lat,
	input  wire logic [7:0] i_addr,
	input  wire logic       i_as_n,
	input  wire logic       i_cs_n,
	input  wire logic       i_oe_n,
	input  wire logic       i_stb,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	output logic      [7:0] o_reg
);
	logic [2:0] sel_q;
	logic [1:0] age_q;
	logic [7:0] junk_q = 8'h00;
	wire        drive = !i_cs_n && !i_oe_n;
	always_ff @(posedge i_clk) begin
		if (!i_as_n) sel_q <= i_addr[2:0];
		if (!drive) age_q <= 2'h0;
		else if (age_q != 2'h3) age_q <= age_q + 2'h1;
		junk_q <= ~junk_q;
		if (i_stb) o_reg <= i_data;
	end
	assign o_data = (drive && sel_q >= i_first && age_q >= i_lat) ? (8'h5a ^ {5'h0, sel_q}) : junk_q;
endmodule // irq_module_model

// File: side_bus_interrupt_timing_tb.sv
// Self-checking bench for the side-bus interrupt timing block.
`timescale 1ns/1ps
`include "side_bus_timing_defs.svh"
module side_bus_interrupt_timing_tb;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hrdy, hresp, as_n, cs_n, oe_n, stb, doe;
	logic [7:0]  addr, dout, din, mreg;
	logic [2:0]  first = 3'h7;
	logic [1:0]  lat = 2'h0;
	int          errors = 0;
	int          tests_run = 0;
	int          n_as, n_oe, n_de, n_st, cyc;
	side_bus_interrupt_timing #(.ADDR_W(8)) i_side_bus_interrupt_timing (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
		.o_bus_addr(addr), .o_addr_latch_strobe_n(as_n), .o_chip_sel_n(cs_n), .o_irq_buf_oe_n(oe_n),
		.o_irq_strobe(stb), .o_bus_data(dout), .o_bus_data_oe(doe), .i_bus_data(din));
	irq_module_model i_irq_module_model (.i_clk(i_clk), .i_first(first), .i_lat(lat), .i_addr(addr), .i_as_n(as_n),
		.i_cs_n(cs_n), .i_oe_n(oe_n), .i_stb(stb), .i_data(dout), .o_data(din), .o_reg(mreg));
	initial forever #2.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (!as_n) n_as++;
		if (!oe_n) n_oe++;
		if (doe) n_de++;
		if (stb) n_st++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge i_clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge i_clk); while (hrdy !== 1'b1);
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic run(input logic [31:0] ctl);
		logic [31:0] r;
		n_as = 0;
		n_oe = 0;
		n_de = 0;
		n_st = 0;
		ahb(1'b1, `OFS_CTRL, ctl, r);
		r = 32'h1;
		for (int k = 0; k < 60 && r[0] !== 1'b0; k++) ahb(1'b0, `OFS_STATUS, 32'h0, r);
		chk("busy", r, 32'h0);
	endtask
	task automatic t_regs();
		logic [31:0] r;
		ahb(1'b0, `OFS_TIMING_LO, 32'h0, r);
		chk("timing reset", r, 32'h0000_7330);
		ahb(1'b1, `OFS_TIMING_LO, 32'hffff_ffff, r);
		ahb(1'b1, `OFS_TIMING_HI, 32'hffff_ffff, r);
		ahb(1'b0, `OFS_TIMING_LO, 32'h0, r);
		chk("timing low", r, 32'h0000_7333);
		ahb(1'b0, `OFS_TIMING_HI, 32'h0, r);
		chk("timing high", r, 32'h0);
		ahb(1'b0, 8'h40, 32'h0, r);
		chk("unmapped", r, 32'h0);
		$display("register test done");
	endtask
	task automatic t_read(input logic [2:0] s, input logic [1:0] irq_read_time, input logic [1:0] ah_as, input logic [1:0] l);
		logic [31:0] r;
		logic [63:0] e;
		e = '0;
		for (int k = s; k < 8; k++) e[8*k +: 8] = 8'h5a ^ 8'(k);
		first <= s;
		lat <= l;
		ahb(1'b1, `OFS_TIMING_LO, {17'h0, s, 2'h0, irq_read_time, 6'h30, ah_as}, r);
		run(32'h1);
		ahb(1'b0, `OFS_IRQ_DATA_LO, 32'h0, r);
		chk("irq low", r, e[31:0]);
		ahb(1'b0, `OFS_IRQ_DATA_HI, 32'h0, r);
		chk("irq high", r, e[63:32]);
		chk("latch strobes", 32'(n_as), 32'(8 - s));
		chk("drive cycles", 32'(n_oe), 32'((8 - s) * (irq_read_time + 1)));
		$display("read test done");
	endtask
	task automatic t_write(input logic [1:0] is, input logic [2:0] a, input logic [7:0] d);
		logic [31:0] r;
		ahb(1'b1, `OFS_TIMING_LO, 32'h0000_7300 | {26'h0, is, 4'h0}, r);
		run({8'h0, d, 5'h0, a, 8'h2});
		chk("captured", {24'h0, mreg}, {24'h0, d});
		chk("setup cycles", 32'(n_de), 32'(is + 2));
		chk("data strobes", 32'(n_st), 32'h1);
		chk("address", {24'h0, addr}, {29'h0, a});
		$display("write test done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_regs();
		t_read(3'h7, 2'h3, 2'h0, 2'h0);
		t_read(3'h3, 2'h0, 2'h3, 2'h0);
		t_read(3'h0, 2'h2, 2'h1, 2'h2);
		t_write(2'h0, 3'h5, 8'ha5);
		t_write(2'h3, 3'h2, 8'h3c);
		print_verdict();
	end
endmodule // side_bus_interrupt_timing_tb
bind side_bus_interrupt_timing side_bus_timing_props #(.ADDR_W(ADDR_W)) i_side_bus_timing_props (
	.i_clk(i_clk), .i_rst_b(i_rst_b), .o_addr_latch_strobe_n(o_addr_latch_strobe_n), .o_chip_sel_n(o_chip_sel_n),
	.o_irq_buf_oe_n(o_irq_buf_oe_n), .o_irq_strobe(o_irq_strobe), .o_bus_data(o_bus_data),
	.o_bus_data_oe(o_bus_data_oe), .o_bus_addr(o_bus_addr));
